// *** core/etx_host_ctrl.sv ***
// host controller that drives the ethernet transmit engine over its serial port
`timescale 1ns/1ps

// Notes on behaviour
// (RULE_01) device makes preamble and delimiter; host never buffers them
// (RULE_02) device pads and appends fcs only when enabled
// (RULE_03) host writes addresses, type/length and payload into buffer memory
// (RULE_04) control byte precedes frame: bits 7-4 zero, huge, pad, fcs, override
// (RULE_05) with override clear the device uses its global configuration
// (RULE_06) host configures mac transmit settings before sending
// (RULE_07) host points start pointer at the control byte location
// (RULE_08) host points end pointer at the last payload byte before requesting
// (RULE_09) host clears done flag and sets both irq enables when wanted
// (RULE_10) setting tx_request starts sending the frame between the pointers
// (RULE_11) device delays sending until a running dma finishes
// (RULE_12) dma start waits while a transmit request is pending
// (RULE_13) no buffer or pointer changes while a transmission runs
// (RULE_14) clearing tx_request cancels the frame; device aborts it
// (RULE_15) at end device clears request, writes status vector, sets done flag
// (RULE_16) device keeps start and end pointers unchanged
// (RULE_17) abort status read by host; late collision gives the cause
// (RULE_18) status vector fields are written least significant byte first
// (RULE_19) vector bit 23 means done, bits 15-0 hold the byte count
// (RULE_20) global fcs append adds a valid fcs to every frame; the device model applies it only to frames with override clear
// (RULE_21) wire bytes run from start pointer plus one through end pointer
module etx_host_ctrl
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output etx_pkg::etx_spi_out_t spi_out,
    input wire logic spi_miso
);
    import etx_pkg::*;

    typedef struct packed {
        etx_fsm_t fsm;
        etx_op_t op;
        logic [2:0] idx;
        logic [3:0] bitn;
        logic [7:0] cnt;
        logic sck;
        logic cs_n;
        logic mosi;
        logic [15:0] sh;
        logic [15:0] rx;
        logic miso_m;
        logic miso_s;
        logic ap_valid;
        logic ap_wr;
        logic [7:0] ap_addr;
        logic [12:0] start_ptr;
        logic [12:0] end_ptr;
        logic [15:0] data;
        logic [3:0] pkt;
        logic irq_en;
        logic tx_active;
        logic tx_req_seen;
        logic abort;
        logic late_col;
        logic [7:0] last_rx;
    } etx_state_t;

    etx_state_t s_r;
    etx_state_t s_nxt;
    etx_step_t step_cur;
    logic cmd_stall;
    logic wr_now;

    ////////////////////////////////////////////////////////////////////////
    // command sequences as serial steps
    function automatic etx_step_t step_f(input etx_op_t op,
                                        input logic [2:0] idx,
                                        input etx_state_t s);
        etx_step_t r;
        r = '{last: 1'b1, b0: 8'h00, b1: 8'h00};
        case (op)
            OP_SETUP:
            begin
                r.last = (idx == 3'h3);
                case (idx)
                    3'h0: r = '{1'b0, {OPC_WR_CTRL, ADR_START_LO},
                                s.start_ptr[7:0]}; // [RULE_07]
                    3'h1: r = '{1'b0, {OPC_WR_CTRL, ADR_START_HI},
                                {3'h0, s.start_ptr[12:8]}};
                    3'h2: r = '{1'b0, {OPC_WR_CTRL, ADR_WRPTR_LO},
                                s.start_ptr[7:0]};
                    default: r = '{1'b1, {OPC_WR_CTRL, ADR_WRPTR_HI},
                                   {3'h0, s.start_ptr[12:8]}};
                endcase
            end
            OP_WCTRL: r.b0 = {OPC_WR_BUF, ARG_WR_BUF};
            OP_WBYTE: r.b0 = {OPC_WR_BUF, ARG_WR_BUF};
            OP_GO:
            begin
                case (idx)
                    3'h0: r = '{1'b0, {OPC_WR_CTRL, ADR_END_LO},
                                s.end_ptr[7:0]}; // [RULE_08]
                    3'h1: r = '{1'b0, {OPC_WR_CTRL, ADR_END_HI},
                                {3'h0, s.end_ptr[12:8]}};
                    3'h2: r = '{1'b0, {OPC_BIT_CLR, ADR_IRQ_FLAG},
                                MSK_TX_DONE_FLAG}; // [RULE_09]
                    3'h3: r = '{1'b0, {OPC_BIT_SET, ADR_IRQ_ENABLE},
                                s.irq_en ? (MSK_TX_IRQ_ENABLE |
                                MSK_GLOBAL_IRQ_ENABLE) : 8'h00}; // [RULE_09]
                    default: r = '{1'b1, {OPC_BIT_SET, ADR_MAIN_CONTROL},
                                   MSK_TX_REQUEST}; // [RULE_10]
                endcase
            end
            OP_CANCEL: r.b0 = {OPC_BIT_CLR, ADR_MAIN_CONTROL}; // [RULE_14]
            OP_POLL:
            begin
                r.last = (idx != 3'h0);
                r.b0 = {OPC_RD_CTRL, (idx == 3'h0) ? ADR_MAIN_CONTROL :
                        ADR_MAIN_STATUS}; // [RULE_17]
            end
            OP_WREG: r.b0 = {OPC_WR_CTRL, s.data[12:8]}; // [RULE_06]
            default: r.last = 1'b1;
        endcase
        // data bytes for buffer and configuration writes
        if (op == OP_WCTRL)
            r.b1 = {4'h0, s.pkt}; // [RULE_04]
        if (op == OP_WBYTE || op == OP_WREG)
            r.b1 = s.data[7:0]; // [RULE_03]
        if (op == OP_CANCEL)
            r.b1 = MSK_TX_REQUEST;
        return r;
    endfunction

    assign step_cur = step_f(s_r.op, s_r.idx, s_r);

    ////////////////////////////////////////////////////////////////////////
    // bus slave handshake
    assign cmd_stall = s_r.ap_valid && s_r.ap_wr && s_r.ap_addr == OFS_CMD &&
                       s_r.fsm != FSM_IDLE;
    assign hreadyout = !cmd_stall;
    assign hresp = 1'b0;
    assign wr_now = s_r.ap_valid && s_r.ap_wr && !cmd_stall;
    assign spi_out = '{sck: s_r.sck, cs_n: s_r.cs_n, mosi: s_r.mosi};

    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (s_r.ap_valid && !s_r.ap_wr)
        begin
            case (s_r.ap_addr)
                OFS_CMD: hrdata = {23'h0, s_r.irq_en, 5'h0, s_r.op};
                OFS_PTR: hrdata = {3'h0, s_r.end_ptr, 3'h0, s_r.start_ptr};
                OFS_DATA: hrdata = {16'h0, s_r.data};
                OFS_PKT: hrdata = {28'h0, s_r.pkt};
                OFS_STAT: hrdata = {16'h0, s_r.last_rx, 3'h0, s_r.late_col,
                                    s_r.abort, s_r.tx_req_seen,
                                    s_r.tx_active, s_r.fsm != FSM_IDLE};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        etx_step_t nx;
        nx = '{last: 1'b1, b0: 8'h00, b1: 8'h00};
        s_nxt = s_r;
        s_nxt.miso_m = spi_miso;
        s_nxt.miso_s = s_r.miso_m;
        if (hreadyout)
        begin
            s_nxt.ap_valid = hsel && htrans[1] && hready;
            s_nxt.ap_wr = hwrite;
            s_nxt.ap_addr = haddr[7:0];
        end
        if (wr_now)
        begin
            case (s_r.ap_addr)
                OFS_PTR:
                    if (!s_r.tx_active)
                    begin
                        s_nxt.start_ptr = hwdata[12:0]; // [RULE_13]
                        s_nxt.end_ptr = hwdata[PTR_END_LSB +: 13];
                    end
                OFS_DATA: s_nxt.data = hwdata[15:0];
                OFS_PKT: s_nxt.pkt = hwdata[3:0];
                OFS_CMD:
                begin
                    s_nxt.irq_en = hwdata[CMD_IRQ_BIT];
                    // buffer and pointer work is refused during a frame
                    if (hwdata[2:0] != OP_NONE && !(s_r.tx_active &&
                        hwdata[2:0] inside {OP_SETUP, OP_WCTRL, OP_WBYTE,
                        OP_GO}))
                    begin // [RULE_13]
                        s_nxt.op = etx_op_t'(hwdata[2:0]);
                        s_nxt.idx = 3'h0;
                        s_nxt.fsm = FSM_GAP;
                        s_nxt.cnt = SCK_HALF;
                    end
                end
                default: s_nxt.ap_wr = 1'b0;
            endcase
        end
        case (s_r.fsm)
            FSM_IDLE: s_nxt.cs_n = 1'b1;
            FSM_SHIFT:
            begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt == SCK_HALF - 8'h01)
                begin
                    s_nxt.cnt = 8'h00;
                    s_nxt.sck = !s_r.sck;
                    if (!s_r.sck)
                        s_nxt.rx = {s_r.rx[14:0], s_r.miso_s};
                    else if (s_r.bitn != LAST_BIT)
                    begin
                        s_nxt.bitn = s_r.bitn + 4'h1;
                        s_nxt.mosi = s_r.sh[14];
                        s_nxt.sh = {s_r.sh[14:0], 1'b0};
                    end
                    else
                    begin
                        s_nxt.fsm = FSM_GAP;
                        s_nxt.cs_n = 1'b1;
                        s_nxt.last_rx = s_r.rx[7:0];
                        if (s_r.op == OP_POLL && s_r.idx == 3'h0)
                        begin
                            s_nxt.tx_req_seen = s_r.rx[BIT_TX_REQUEST];
                            if (!s_r.rx[BIT_TX_REQUEST])
                                s_nxt.tx_active = 1'b0; // [RULE_17]
                        end
                        if (s_r.op == OP_POLL && s_r.idx != 3'h0)
                        begin
                            s_nxt.abort = s_r.rx[BIT_TX_ABORT]; // [RULE_17]
                            s_nxt.late_col = s_r.rx[BIT_LATE_COLLISION];
                        end
                        if (s_r.op == OP_GO && step_cur.last)
                        begin
                            s_nxt.tx_active = 1'b1; // [RULE_10]
                            s_nxt.tx_req_seen = 1'b1;
                        end
                    end
                end
            end
            FSM_GAP:
            begin
                s_nxt.cnt = s_r.cnt + 8'h01;
                if (s_r.cnt >= SCK_HALF - 8'h01)
                begin
                    s_nxt.cnt = 8'h00;
                    if (s_r.cs_n && s_r.op != OP_NONE)
                    begin
                        nx = step_f(s_r.op, s_r.idx, s_r);
                        s_nxt.fsm = FSM_SHIFT;
                        s_nxt.cs_n = 1'b0;
                        s_nxt.sck = 1'b0;
                        s_nxt.bitn = 4'h0;
                        s_nxt.sh = {nx.b0, nx.b1};
                        s_nxt.mosi = nx.b0[7];
                        s_nxt.op = s_r.op;
                        s_nxt.idx = s_r.idx;
                    end
                    else
                    begin
                        s_nxt.fsm = FSM_IDLE;
                        s_nxt.op = OP_NONE;
                    end
                end
            end
            default: s_nxt.fsm = FSM_IDLE;
        endcase
        // a finished step either moves to the next one or closes the command
        if (s_r.fsm == FSM_SHIFT && s_nxt.fsm == FSM_GAP)
        begin
            if (step_cur.last)
                s_nxt.op = OP_NONE;
            else
                s_nxt.idx = s_r.idx + 3'h1;
        end
        if (!rstn)
        begin
            s_nxt = '0;
            s_nxt.cs_n = 1'b1;
            s_nxt.start_ptr = PTR_RST;
            s_nxt.end_ptr = PTR_RST;
        end
    end

    always_ff @(posedge clk)
    begin
        s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_ctrl_byte;
        s_r.fsm == FSM_SHIFT && s_r.op == OP_WCTRL && s_r.bitn == 4'h0 |->
            s_r.sh[7:4] == 4'h0 && s_r.sh[3:0] == s_r.pkt;
    endproperty
    a_ctrl_byte: assert property (p_ctrl_byte) // [RULE_04]
        else $error("control byte upper bits not zero");

    property p_start_ptr;
        s_r.fsm == FSM_SHIFT && s_r.op == OP_SETUP && s_r.idx == 3'h0 &&
        s_r.bitn == 4'h0 |->
            s_r.sh == {OPC_WR_CTRL, ADR_START_LO, s_r.start_ptr[7:0]};
    endproperty
    a_start_ptr: assert property (p_start_ptr) // [RULE_07]
        else $error("start pointer step carries wrong word");

    property p_end_ptr;
        s_r.fsm == FSM_SHIFT && s_r.op == OP_GO && s_r.idx == 3'h0 &&
        s_r.bitn == 4'h0 |->
            s_r.sh == {OPC_WR_CTRL, ADR_END_LO, s_r.end_ptr[7:0]};
    endproperty
    a_end_ptr: assert property (p_end_ptr) // [RULE_08]
        else $error("end pointer step carries wrong word");

    property p_flag_clear;
        s_r.fsm == FSM_SHIFT && s_r.op == OP_GO && s_r.idx == 3'h2 &&
        s_r.bitn == 4'h0 |->
            s_r.sh == {OPC_BIT_CLR, ADR_IRQ_FLAG, MSK_TX_DONE_FLAG};
    endproperty
    a_flag_clear: assert property (p_flag_clear) // [RULE_09]
        else $error("done flag not cleared before start");

    property p_go_active;
        s_r.fsm == FSM_SHIFT && s_r.op == OP_GO && s_r.idx == 3'h4 &&
        s_nxt.fsm == FSM_GAP |=> s_r.tx_active && s_r.op == OP_NONE;
    endproperty
    a_go_active: assert property (p_go_active) // [RULE_10]
        else $error("request step did not mark frame active");

    property p_no_buf_write;
        s_r.fsm == FSM_SHIFT && s_r.op inside {OP_WBYTE, OP_WCTRL} |->
            !s_r.tx_active;
    endproperty
    a_no_buf_write: assert property (p_no_buf_write) // [RULE_13]
        else $error("buffer write during transmission");

    property p_cancel;
        s_r.fsm == FSM_SHIFT && s_r.op == OP_CANCEL && s_r.bitn == 4'h0 |->
            s_r.sh == {OPC_BIT_CLR, ADR_MAIN_CONTROL, MSK_TX_REQUEST};
    endproperty
    a_cancel: assert property (p_cancel) // [RULE_14]
        else $error("cancel step carries wrong word");

    property p_poll_abort;
        s_r.fsm == FSM_SHIFT && s_r.op == OP_POLL && s_r.idx == 3'h1 &&
        s_nxt.fsm == FSM_GAP |=>
            s_r.abort == $past(s_r.rx[BIT_TX_ABORT]) &&
            s_r.late_col == $past(s_r.rx[BIT_LATE_COLLISION]);
    endproperty
    a_poll_abort: assert property (p_poll_abort) // [RULE_17]
        else $error("abort status not taken from status read");

    property p_frame_bits;
        $fell(s_r.cs_n) |-> !s_r.sck [*4] ##1 s_r.sck;
    endproperty
    a_frame_bits: assert property (p_frame_bits) // [RULE_03]
        else $error("serial clock timing wrong after select");
endmodule // etx_host_ctrl

// *** core/etx_pkg.sv ***
// constants, types and device map for the ethernet transmit host controller
package etx_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_PERIOD_NS = 800;
    // serial clock half period in system clocks, must stay at 3 or more
    localparam logic [7:0] SCK_HALF = 8'(SCK_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [3:0] LAST_BIT = 4'hf;

    // own register map, byte offsets on the ahb-lite bus
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_PTR = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_PKT = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam int CMD_IRQ_BIT = 8;
    localparam int PTR_END_LSB = 16;
    localparam logic [12:0] PTR_RST = 13'h0000;

    // serial command opcodes (upper three bits of the first byte)
    localparam logic [2:0] OPC_RD_CTRL = 3'h0;
    localparam logic [2:0] OPC_WR_CTRL = 3'h2;
    localparam logic [2:0] OPC_WR_BUF = 3'h3;
    localparam logic [2:0] OPC_BIT_SET = 3'h4;
    localparam logic [2:0] OPC_BIT_CLR = 3'h5;
    localparam logic [4:0] ARG_WR_BUF = 5'h1a;

    // device register addresses
    localparam logic [4:0] ADR_IRQ_ENABLE = 5'h1b;
    localparam logic [4:0] ADR_IRQ_FLAG = 5'h1c;
    localparam logic [4:0] ADR_MAIN_STATUS = 5'h1d;
    localparam logic [4:0] ADR_MAIN_CONTROL = 5'h1f;
    localparam logic [4:0] ADR_WRPTR_LO = 5'h02;
    localparam logic [4:0] ADR_WRPTR_HI = 5'h03;
    localparam logic [4:0] ADR_START_LO = 5'h04;
    localparam logic [4:0] ADR_START_HI = 5'h05;
    localparam logic [4:0] ADR_END_LO = 5'h06;
    localparam logic [4:0] ADR_END_HI = 5'h07;

    // device bit positions
    localparam logic [7:0] MSK_TX_REQUEST = 8'h08;
    localparam logic [7:0] MSK_TX_DONE_FLAG = 8'h08;
    localparam logic [7:0] MSK_TX_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] MSK_GLOBAL_IRQ_ENABLE = 8'h80;
    localparam int BIT_TX_REQUEST = 3;
    localparam int BIT_TX_ABORT = 1;
    localparam int BIT_LATE_COLLISION = 4;

    typedef enum logic [1:0] {
        FSM_IDLE = 2'b00,
        FSM_SHIFT = 2'b01,
        FSM_GAP = 2'b11
    } etx_fsm_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SETUP = 3'h1,
        OP_WCTRL = 3'h2,
        OP_WBYTE = 3'h3,
        OP_GO = 3'h4,
        OP_CANCEL = 3'h5,
        OP_POLL = 3'h6,
        OP_WREG = 3'h7
    } etx_op_t;

    typedef struct packed {
        logic last;
        logic [7:0] b0;
        logic [7:0] b1;
    } etx_step_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
    } etx_spi_out_t;
endpackage

// *** verif/etx_dev_model.sv ***
// behavioural model of the transmit device behind the serial port
`timescale 1ns/1ps
module etx_dev_model
#(
    parameter logic GLOBAL_FCS_APPEND = 1'b1,
    parameter logic GLOBAL_PAD_CFG = 1'b1
)
(
    input wire logic clk,
    input wire etx_pkg::etx_spi_out_t spi,
    output logic miso,
    input wire logic [11:0] delay,
    input wire logic fail
);
    import etx_pkg::*;
    logic [7:0] regs [0:31];
    logic [7:0] mem [0:8191];
    logic [15:0] sh;
    logic [7:0] rb;
    logic [12:0] p;
    int cnt;
    int busy;
    initial
    begin
        foreach (regs[i]) regs[i] = 8'h00;
        miso = 1'b0;
        cnt = 0;
        busy = 0;
    end
    ////////////////////////////////////////////////////////////////////
    function automatic logic [12:0] ptr(input logic [4:0] lo);
        return {regs[lo + 5'h01][4:0], regs[lo]};
    endfunction
    // start and end pointers are only read here, never written
    task automatic finish(input logic ab, input logic late);
        logic [55:0] v;
        logic [7:0] ctl;
        logic [15:0] len;
        v = 56'h0;
        p = ptr(ADR_END_LO) + 13'h1;
        ctl = mem[ptr(ADR_START_LO)];
        len = 16'(ptr(ADR_END_LO) - ptr(ADR_START_LO));
        if ((ctl[0] ? ctl[2] : GLOBAL_PAD_CFG) && len < 16'h003c)
            len = 16'h003c;
        if (ctl[0] ? ctl[1] : GLOBAL_FCS_APPEND)
            len = len + 16'h0004;
        // preamble and delimiter are not counted in the length
        v[15:0] = len;
        v[23] = !ab;
        v[29] = late;
        for (int i = 0; i < 7; i++)
            mem[p + 13'(i)] = v[8*i +: 8];
        regs[ADR_MAIN_CONTROL] &= ~MSK_TX_REQUEST;
        regs[ADR_IRQ_FLAG] |= MSK_TX_DONE_FLAG;
        regs[ADR_MAIN_STATUS][BIT_TX_ABORT] = ab;
        regs[ADR_MAIN_STATUS][BIT_LATE_COLLISION] = late;
        busy = 0;
    endtask
    task automatic decode(input logic [2:0] op, input logic [4:0] a,
                          input logic [7:0] d);
        logic was;
        was = regs[ADR_MAIN_CONTROL][BIT_TX_REQUEST];
        case (op)
            OPC_WR_CTRL: regs[a] = d;
            OPC_BIT_SET: regs[a] = regs[a] | d;
            OPC_BIT_CLR: regs[a] = regs[a] & ~d;
            OPC_WR_BUF:
            begin
                p = ptr(ADR_WRPTR_LO);
                mem[p] = d;
                p = p + 13'h1;
                {regs[ADR_WRPTR_HI], regs[ADR_WRPTR_LO]} = {3'h0, p};
            end
            default: ;
        endcase
        if (!was && regs[ADR_MAIN_CONTROL][BIT_TX_REQUEST])
            busy = delay + 1;
        if (was && !regs[ADR_MAIN_CONTROL][BIT_TX_REQUEST] && busy > 0)
            finish(1'b1, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////
    always @(posedge spi.sck)
    begin
        if (!spi.cs_n)
        begin
            sh = {sh[14:0], spi.mosi};
            cnt++;
        end
    end
    // read data changes after each falling serial clock edge of the second byte
    always @(negedge spi.sck)
    begin
        if (!spi.cs_n && cnt >= 8 && cnt < 16)
        begin
            if (cnt == 8)
                rb = regs[sh[4:0]];
            miso = rb[15 - cnt];
        end
    end
    always @(posedge spi.cs_n)
    begin
        miso = ~miso;
        if (cnt == 16)
            decode(sh[15:13], sh[12:8], sh[7:0]);
        cnt = 0;
    end
    // the countdown is the frame being sent; no new one starts meanwhile
    always @(posedge clk)
    begin
        if (busy > 1)
            busy--;
        else if (busy == 1)
            finish(fail, fail);
    end
endmodule // etx_dev_model

// *** verif/test_etx_host_ctrl.sv ***
// self-checking bench for the ethernet transmit host controller
`timescale 1ns/1ps
module test_etx_host_ctrl;
    import etx_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    etx_spi_out_t spi_out;
    logic spi_miso;
    logic [11:0] delay = 12'h200;
    logic fail = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;
    int seed = 12;
    localparam logic GLOBAL_FCS_APPEND = 1'b1;
    localparam logic GLOBAL_PAD_CFG = 1'b1;
    logic [31:0] rd;
    logic [31:0] hrd;
    logic rdy;
    always #50 clk = ~clk;
    etx_host_ctrl etx_host_ctrl_i (.clk(clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .spi_out(spi_out),
        .spi_miso(spi_miso));
    etx_dev_model #(.GLOBAL_FCS_APPEND(GLOBAL_FCS_APPEND),
        .GLOBAL_PAD_CFG(GLOBAL_PAD_CFG)) etx_dev_model_i (.clk(clk),
        .spi(spi_out), .miso(spi_miso), .delay(delay), .fail(fail));
    ////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic guard(input logic ok);
        if (!ok)
        begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // ready and read data are taken as they stand at the rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        rdy = 1'b0;
        while (!rdy)
        begin
            @(negedge clk);
            rdy = hreadyout;
            hrd = hrdata;
            @(posedge clk);
            n++;
            guard(n < 2000);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrd;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input string nm,
                       input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic cmd(input etx_op_t op, input logic irq);
        int n;
        wr(OFS_CMD, {23'h0, irq, 5'h0, op});
        n = 0;
        do
        begin
            bus(1'b0, OFS_STAT, 32'h0);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 1000);
        guard(rd[0] === 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////
    // wire byte count of a frame as the status vector reports it
    function automatic logic [15:0] vec_len(input logic [12:0] nb,
                                            input logic [3:0] pk);
        logic [15:0] r;
        r = 16'(nb);
        if ((pk[0] ? pk[2] : GLOBAL_PAD_CFG) && r < 16'h003c)
            r = 16'h003c;
        if (pk[0] ? pk[1] : GLOBAL_FCS_APPEND)
            r = r + 16'h0004;
        return r;
    endfunction
    task automatic frame(input logic irq, input logic fl, input logic cn);
        logic [12:0] s;
        logic [12:0] e;
        logic [7:0] pk;
        logic [7:0] db [4];
        logic [7:0] st;
        logic [7:0] ie;
        int n;
        s = 13'($random(seed)) & 13'h0ffe;
        n = 1 + ($random(seed) & 3);
        e = s + 13'(n);
        pk = {4'h0, 4'($random(seed))};
        fail <= fl;
        delay <= cn ? 12'hfff : (12'($random(seed)) & 12'h0ff) | 12'h200;
        wr(OFS_PTR, {3'h0, e, 3'h0, s});
        cmd(OP_SETUP, 1'b0);
        wr(OFS_PKT, 32'(pk));
        cmd(OP_WCTRL, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            db[i] = 8'($random(seed));
            wr(OFS_DATA, 32'(db[i]));
            cmd(OP_WBYTE, 1'b0);
        end
        ie = etx_dev_model_i.regs[ADR_IRQ_ENABLE];
        if (irq)
            ie = ie | MSK_TX_IRQ_ENABLE | MSK_GLOBAL_IRQ_ENABLE;
        cmd(OP_GO, irq);
        chk("active", 32'(rd[1]), 32'h1);
        rdc(OFS_CMD, "cmd", {23'h0, irq, 5'h0, OP_NONE});
        chk("start", 32'(etx_dev_model_i.ptr(ADR_START_LO)),
            32'(s));
        chk("end", 32'(etx_dev_model_i.ptr(ADR_END_LO)),
            32'(e));
        chk("flag", 32'(etx_dev_model_i.regs[ADR_IRQ_FLAG]
            & MSK_TX_DONE_FLAG), 32'h0);
        chk("irqen", 32'(etx_dev_model_i.regs[ADR_IRQ_ENABLE]),
            32'(ie));
        chk("ctrl", 32'(etx_dev_model_i.mem[s]), 32'(pk));
        for (int i = 0; i < n; i++)
            chk("data", 32'(etx_dev_model_i.mem[s + 13'(i + 1)]),
                32'(db[i]));
        wr(OFS_PTR, ~{3'h0, e, 3'h0, s});
        rdc(OFS_PTR, "ptr", {3'h0, e, 3'h0, s});
        if (cn)
            cmd(OP_CANCEL, 1'b0);
        n = 0;
        do
        begin
            cmd(OP_POLL, 1'b0);
            n++;
        end
        while (rd[1] !== 1'b0 && n < 60);
        guard(rd[1] === 1'b0);
        st = 8'h0;
        st[BIT_TX_ABORT] = fl | cn;
        st[BIT_LATE_COLLISION] = fl;
        chk("abort", 32'(rd[4:3]),
            {30'h0, fl, fl | cn});
        chk("status", 32'(rd[15:8]), 32'(st));
        chk("reqclr", 32'(etx_dev_model_i.regs[ADR_MAIN_CONTROL]
            & MSK_TX_REQUEST), 32'h0);
        chk("vec_len", {16'h0, etx_dev_model_i.mem[e + 13'h2],
            etx_dev_model_i.mem[e + 13'h1]},
            32'(vec_len(e - s, pk[3:0])));
        chk("vec_done", 32'(etx_dev_model_i.mem[e + 13'h3][7]),
            32'(!(fl | cn)));
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [4:0] a;
        logic [7:0] d;
        logic c;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("spi_rst", 32'(spi_out), 32'h2);
        @(posedge clk);
        rstn <= 1'b1;
        rdc(OFS_STAT, "stat_rst", 32'h0);
        rdc(OFS_PTR, "ptr_rst", {3'h0, PTR_RST, 3'h0, PTR_RST});
        wr(8'h14, 32'($random(seed)));
        rdc(8'h14, "unmapped", 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            a = 5'h08 | 5'($random(seed) & 7);
            d = 8'($random(seed));
            wr(OFS_DATA, {19'h0, a, d});
            cmd(OP_WREG, 1'b0);
            chk("wreg", 32'(etx_dev_model_i.regs[a]), 32'(d));
        end
        frame(1'b1, 1'b0, 1'b0);
        frame(1'b0, 1'b1, 1'b0);
        frame(1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            c = 1'($random(seed));
            frame(1'($random(seed)), 1'($random(seed)) & !c, c);
        end
        chk("hresp", 32'(hresp), 32'h0);
        give_verdict();
    end
endmodule // test_etx_host_ctrl
